// ### core/drive_value_pkg.sv
// Constants, types and helper functions of the drive value memory
package drive_value_pkg;

   // ==========================================================
   // Widths and types
   localparam int NumEntries = 15;
   localparam int NumPeaks   = 8;
   localparam int NumMeans   = 5;

   typedef logic signed [15:0] value_t;
   typedef logic        [31:0] data_t;
   typedef logic        [31:0] energy_t;
   typedef logic        [9:0]  index_t;
   typedef logic        [7:0]  sel_t;
   typedef logic        [14:0] mask_t;
   typedef logic        [15:0] count_t;
   typedef logic signed [31:0] sum_t;

   // ==========================================================
   // Reset selector codes
   localparam sel_t SelNone       = 8'h00;
   localparam sel_t SelFirst      = 8'h01;
   localparam sel_t SelLastSingle = 8'h0d;
   localparam sel_t SelEnergyPos  = 8'h10;
   localparam sel_t SelEnergyNeg  = 8'h11;
   localparam sel_t SelAllPeaks   = 8'h64;
   localparam sel_t SelAllMeans   = 8'h65;
   localparam sel_t SelAllValues  = 8'h66;

   // ==========================================================
   // Entry positions in the clear mask
   localparam int EntEnergyPos = 13;
   localparam int EntEnergyNeg = 14;
   localparam mask_t EntryOne   = 15'h0001;
   localparam mask_t PeakMask   = 15'h0d57;
   localparam mask_t MeanMask   = 15'h12a8;
   localparam mask_t EnergyMask = 15'h6000;
   localparam mask_t AllMask    = 15'h7fff;
   // Peak order: long term, short term, Vdc, heat sink, inside,
   // current, power positive, power negative
   localparam int PeakBit [NumPeaks] = '{0, 1, 2, 4, 6, 8, 10, 11};
   // Mean order: Vdc, heat sink, inside, current, power
   localparam int MeanBit [NumMeans] = '{3, 5, 7, 9, 12};

   // ==========================================================
   // Status word bit positions
   localparam int BitMissingA = 0;
   localparam int BitMissingB = 1;
   localparam int BitSwOffA   = 2;
   localparam int BitSwOffB   = 3;
   localparam int BitTimeoutA = 4;
   localparam int BitTimeoutB = 5;
   localparam int BitDiagErr  = 6;
   localparam int BitFaultErr = 7;

   // ==========================================================
   // Parameter numbers for reads
   localparam index_t ParResetSel  = 10'h0ed;
   localparam index_t ParLongTerm  = 10'h0e7;
   localparam index_t ParShortTerm = 10'h0e8;
   localparam index_t ParStatus    = 10'h115;
   localparam index_t ParPeakVdc   = 10'h11f;
   localparam index_t ParMeanVdc   = 10'h120;
   localparam index_t ParPeakSink  = 10'h121;
   localparam index_t ParMeanSink  = 10'h122;
   localparam index_t ParPeakIns   = 10'h123;
   localparam index_t ParMeanIns   = 10'h124;
   localparam index_t ParPeakCur   = 10'h125;
   localparam index_t ParMeanCur   = 10'h126;
   localparam index_t ParPeakPpos  = 10'h127;
   localparam index_t ParPeakPneg  = 10'h128;
   localparam index_t ParMeanPow   = 10'h129;
   localparam index_t ParEnergyPos = 10'h12d;
   localparam index_t ParEnergyNeg = 10'h12e;

   // ==========================================================
   // Reset values and limits
   localparam logic [7:0] StatusReset   = 8'h00;
   localparam sel_t       SelectorReset = 8'h00;
   localparam count_t     CountMax      = 16'hffff;
   localparam energy_t    EnergyMax     = 32'hffffffff;
   localparam value_t     ValueMax      = 16'sh7fff;

   // ==========================================================
   // Functions
   function automatic mask_t clear_mask(input sel_t sel);
      mask_t m;
      m = '0;
      case (sel)
         SelAllPeaks:  m = PeakMask;
         SelAllMeans:  m = MeanMask;
         SelAllValues: m = AllMask;
         SelEnergyPos: m = EntryOne << EntEnergyPos;
         SelEnergyNeg: m = EntryOne << EntEnergyNeg;
         default: begin
            if (sel >= SelFirst && sel <= SelLastSingle)
               m = EntryOne << (sel - SelFirst);
         end
      endcase
      return m;
   endfunction

   function automatic energy_t add_sat(input energy_t e, input value_t v);
      logic [32:0] s;
      s = {1'b0, e} + {17'h00000, v};
      return s[32] ? EnergyMax : s[31:0];
   endfunction

   function automatic data_t widen(input value_t v);
      return {{16{v[15]}}, v};
   endfunction

   function automatic value_t neg_mag(input value_t v);
      logic signed [16:0] n;
      n = -{v[15], v};
      if (v >= 0)
         return '0;
      return (n > 17'sh07fff) ? ValueMax : value_t'(n[15:0]);
   endfunction

endpackage

// ### core/safety_status_word.sv
// Safety input status word and linkable safety input sources
module safety_status_word (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       ce,
   // Safety input pins
   input  wire logic       safetyPinA,
   input  wire logic       safetyPinB,
   // Diagnostic flags
   input  wire logic       inputMissingA,
   input  wire logic       inputMissingB,
   input  wire logic       switchOffA,
   input  wire logic       switchOffB,
   input  wire logic       timeoutA,
   input  wire logic       timeoutB,
   input  wire logic       diagnosisError,
   input  wire logic       faultErrorFlag,
   // Outputs
   output logic [7:0]      statusWord,
   output logic            safetyInputA,
   output logic            safetyInputAInv,
   output logic            safetyInputB,
   output logic            safetyInputBInv
);
   import drive_value_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic syncA1_r, syncA2_r, syncB1_r, syncB2_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA1_r <= 1'b0;
         syncA2_r <= 1'b0;
         syncB1_r <= 1'b0;
         syncB2_r <= 1'b0;
      end else if (ce) begin
         syncA1_r <= safetyPinA;
         syncA2_r <= syncA1_r;
         syncB1_r <= safetyPinB;
         syncB2_r <= syncB1_r;
      end
   end

   // ==========================================================
   // Status word and sources
   logic [7:0] status_r, status_nxt;
   logic [3:0] src_r, src_nxt;

   always_comb begin
      status_nxt              = '0;
      status_nxt[BitMissingA] = inputMissingA;  // [R1]
      status_nxt[BitMissingB] = inputMissingB;  // [R1]
      status_nxt[BitSwOffA]   = switchOffA;     // [R2]
      status_nxt[BitSwOffB]   = switchOffB;     // [R2]
      status_nxt[BitTimeoutA] = timeoutA;       // [R3]
      status_nxt[BitTimeoutB] = timeoutB;       // [R3]
      status_nxt[BitDiagErr]  = diagnosisError; // [R3]
      status_nxt[BitFaultErr] = faultErrorFlag; // [R3]
      // Plain and inverted copies
      src_nxt = {syncB2_r, !syncB2_r, syncA2_r, !syncA2_r}; // [R5]
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= StatusReset;
         src_r    <= 4'h5;
      end else if (ce) begin
         status_r <= status_nxt;
         src_r    <= src_nxt;
      end
   end

   assign statusWord      = status_r;
   assign safetyInputA    = src_r[1];
   assign safetyInputAInv = src_r[0];
   assign safetyInputB    = src_r[3];
   assign safetyInputBInv = src_r[2];

   // ==========================================================
   // Checks
   chk_status_bits: assert property ( // [R1] [R2] [R3]
      @(posedge clk) disable iff (!reset_n)
      ce |=> statusWord == $past({faultErrorFlag, diagnosisError, timeoutB,
         timeoutA, switchOffB, switchOffA, inputMissingB, inputMissingA}))
      else $error("status word does not follow flags");

   // Three enabled edges from pin to source register
   chk_source_inv: assert property ( // [R5]
      @(posedge clk) disable iff (!reset_n)
      ce [*4] |-> safetyInputA == $past(safetyPinA, 3)
         && safetyInputB == $past(safetyPinB, 3)
         && safetyInputAInv == !safetyInputA
         && safetyInputBInv == !safetyInputB)
      else $error("safety source not synchronised pin or complement");

endmodule

// ### core/mean_value_accumulator.sv
// Running mean over the observation period, cleared on request
module mean_value_accumulator (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              ce,
   // Samples
   input  wire logic              sampleValid,
   input  drive_value_pkg::value_t sample,
   input  wire logic              clear,
   // Result
   output drive_value_pkg::value_t meanValue
);
   import drive_value_pkg::*;

   sum_t   sum_r, sum_nxt;
   count_t count_r, count_nxt;
   value_t mean_r, mean_nxt;

   always_comb begin
      sum_nxt   = sum_r;
      count_nxt = count_r;
      mean_nxt  = '0;
      if (count_r != '0)
         mean_nxt = value_t'(sum_r / $signed({1'b0, count_r})); // [R20] [R7]
      if (clear) begin
         sum_nxt   = '0; // [R20] [R12]
         count_nxt = '0;
         mean_nxt  = '0;
      end else if (sampleValid && count_r != CountMax) begin
         // Count stops at full scale so the sum cannot overflow
         sum_nxt   = sum_r + sum_t'(sample);
         count_nxt = count_r + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sum_r   <= '0;
         count_r <= '0;
         mean_r  <= '0;
      end else if (ce) begin
         sum_r   <= sum_nxt;
         count_r <= count_nxt;
         mean_r  <= mean_nxt;
      end
   end

   assign meanValue = mean_r;

   // ==========================================================
   // Checks
   sequence clearSeen;
      ce && clear;
   endsequence

   chk_mean_restart: assert property ( // [R20] [R17]
      @(posedge clk) disable iff (!reset_n)
      clearSeen |=> count_r == '0 && sum_r == '0 ##1 meanValue == '0)
      else $error("mean not restarted after clear");

   chk_count_step: assert property ( // [R20]
      @(posedge clk) disable iff (!reset_n)
      ce && sampleValid && !clear && count_r != CountMax
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("sample count did not advance");

endmodule

// ### core/drive_value_memory.sv
// Drive diagnostic value store: status word, peaks, means, energies
// Operation
// [R1] Status bit 0 flags first safety input missing, bit 1 the second.
// [R2] Status bits 2 and 3 flag switch-off demanded by input A and B.
// [R3] Bits 4,5 flag input timeouts; bit 6 diagnosis, bit 7 fault error.
// [R4] Healthy wiring normally shows status 0 or 3 only.
// [R5] Plain and inverted state of each safety input are offered as sources.
// [R6] Peak registers hold maximum DC link voltage and both temperatures.
// [R7] Means over the observation period for voltage, temps, current, power.
// [R8] Peak utilisation of long-term and short-term overload allowance kept.
// [R9] Largest positive and largest negative active power tracked apart.
// [R10] Motoring energy and generating energy accumulated in separate totals.
// [R11] Peak current magnitude tracked.
// [R12] Selected entry and its accumulated period data are set to zero.
// [R13] Selector 0 changes nothing.
// [R14] Selectors 1 to 13 each clear one single entry.
// [R15] Selector 16 clears motoring energy, 17 generating energy.
// [R16] Selector 100 clears all peaks.
// [R17] Selector 101 clears all means with their sample data.
// [R18] Selector 102 clears the whole memory.
// [R19] Every entry is readable over the parameter read port.
// [R20] Mean is running sum over running count, both restarted on clear.
// [R21] Each selector write clears once, not repeatedly.
module drive_value_memory (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               ce,
   // Safety input pins
   input  wire logic               safetyPinA,
   input  wire logic               safetyPinB,
   // Safety diagnostic flags
   input  wire logic               inputMissingA,
   input  wire logic               inputMissingB,
   input  wire logic               switchOffA,
   input  wire logic               switchOffB,
   input  wire logic               timeoutA,
   input  wire logic               timeoutB,
   input  wire logic               diagnosisError,
   input  wire logic               faultErrorFlag,
   // Linkable safety input sources
   output logic                    safetyInputA,
   output logic                    safetyInputAInv,
   output logic                    safetyInputB,
   output logic                    safetyInputBInv,
   // Measured values
   input  wire logic               sampleValid,
   input  drive_value_pkg::value_t longTermUtil,
   input  drive_value_pkg::value_t shortTermUtil,
   input  drive_value_pkg::value_t dcLinkVoltage,
   input  drive_value_pkg::value_t heatSinkTemperature,
   input  drive_value_pkg::value_t insideTemperature,
   input  drive_value_pkg::value_t currentMagnitude,
   input  drive_value_pkg::value_t activePower,
   // Reset selector write
   input  wire logic               selWrEn,
   input  drive_value_pkg::sel_t   selWrData,
   // Parameter read
   input  wire logic               rdEn,
   input  drive_value_pkg::index_t rdIndex,
   output drive_value_pkg::data_t  rdData,
   output logic                    rdValid
);
   import drive_value_pkg::*;

   // ==========================================================
   // Status word
   logic [7:0] statusWord;

   // Healthy wiring reads 0 or 3; nothing here forces it
   safety_status_word u_status ( // [R4]
      .clk             (clk),
      .reset_n         (reset_n),
      .ce              (ce),
      .safetyPinA      (safetyPinA),
      .safetyPinB      (safetyPinB),
      .inputMissingA   (inputMissingA),
      .inputMissingB   (inputMissingB),
      .switchOffA      (switchOffA),
      .switchOffB      (switchOffB),
      .timeoutA        (timeoutA),
      .timeoutB        (timeoutB),
      .diagnosisError  (diagnosisError),
      .faultErrorFlag  (faultErrorFlag),
      .statusWord      (statusWord),
      .safetyInputA    (safetyInputA),
      .safetyInputAInv (safetyInputAInv),
      .safetyInputB    (safetyInputB),
      .safetyInputBInv (safetyInputBInv)
   );

   // ==========================================================
   // Reset selector
   sel_t  sel_r, sel_nxt;
   logic  clearPend_r, clearPend_nxt;
   mask_t clearMask;

   always_comb begin
      sel_nxt       = sel_r;
      clearPend_nxt = 1'b0; // [R21]
      if (selWrEn) begin
         sel_nxt       = selWrData;
         clearPend_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_r       <= SelectorReset;
         clearPend_r <= 1'b0;
      end else if (ce) begin
         sel_r       <= sel_nxt;
         clearPend_r <= clearPend_nxt;
      end
   end

   // One clear pulse per write; decode covers 0, 1..13, 16, 17, 100..102
   assign clearMask = clearPend_r ? clear_mask(sel_r) : '0; // [R13] [R14]

   // ==========================================================
   // Peak values
   value_t peak_r   [NumPeaks];
   value_t peak_nxt [NumPeaks];
   value_t peakIn   [NumPeaks];
   logic   peaksZero;

   always_comb begin
      peakIn[0] = longTermUtil;        // [R8]
      peakIn[1] = shortTermUtil;       // [R8]
      peakIn[2] = dcLinkVoltage;       // [R6]
      peakIn[3] = heatSinkTemperature; // [R6]
      peakIn[4] = insideTemperature;   // [R6]
      peakIn[5] = currentMagnitude;    // [R11]
      peakIn[6] = (activePower > 0) ? activePower : '0; // [R9]
      peakIn[7] = neg_mag(activePower);                 // [R9]
   end

   always_comb begin
      for (int k = 0; k < NumPeaks; k++) begin
         peak_nxt[k] = peak_r[k];
         if (clearMask[PeakBit[k]])
            peak_nxt[k] = '0; // [R12] [R16]
         else if (sampleValid && peakIn[k] > peak_r[k])
            peak_nxt[k] = peakIn[k]; // [R6] [R11]
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < NumPeaks; k++)
            peak_r[k] <= '0;
      end else if (ce) begin
         for (int k = 0; k < NumPeaks; k++)
            peak_r[k] <= peak_nxt[k];
      end
   end

   always_comb begin
      peaksZero = 1'b1;
      for (int k = 0; k < NumPeaks; k++)
         if (peak_r[k] != '0)
            peaksZero = 1'b0;
   end

   // ==========================================================
   // Mean values
   value_t meanIn  [NumMeans];
   value_t meanVal [NumMeans];

   always_comb begin
      meanIn[0] = dcLinkVoltage;
      meanIn[1] = heatSinkTemperature;
      meanIn[2] = insideTemperature;
      meanIn[3] = currentMagnitude;
      meanIn[4] = activePower;
   end

   for (genvar m = 0; m < NumMeans; m++) begin : g_mean
      mean_value_accumulator u_mean ( // [R7]
         .clk         (clk),
         .reset_n     (reset_n),
         .ce          (ce),
         .sampleValid (sampleValid),
         .sample      (meanIn[m]),
         .clear       (clearMask[MeanBit[m]]), // [R17]
         .meanValue   (meanVal[m])
      );
   end

   // ==========================================================
   // Energy totals
   energy_t energyPos_r, energyPos_nxt;
   energy_t energyNeg_r, energyNeg_nxt;

   always_comb begin
      energyPos_nxt = energyPos_r;
      energyNeg_nxt = energyNeg_r;
      if (clearMask[EntEnergyPos])
         energyPos_nxt = '0; // [R15] [R18]
      else if (sampleValid && activePower > 0)
         energyPos_nxt = add_sat(energyPos_r, activePower); // [R10]
      if (clearMask[EntEnergyNeg])
         energyNeg_nxt = '0; // [R15] [R18]
      else if (sampleValid && activePower < 0)
         energyNeg_nxt = add_sat(energyNeg_r, neg_mag(activePower)); // [R10]
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         energyPos_r <= '0;
         energyNeg_r <= '0;
      end else if (ce) begin
         energyPos_r <= energyPos_nxt;
         energyNeg_r <= energyNeg_nxt;
      end
   end

   // ==========================================================
   // Parameter read port
   data_t rdData_r, rdData_nxt;
   logic  rdValid_r, rdValid_nxt;

   always_comb begin
      rdValid_nxt = rdEn;
      rdData_nxt  = rdData_r;
      if (rdEn) begin
         case (rdIndex) // [R19]
            ParStatus:    rdData_nxt = {24'h000000, statusWord};
            ParResetSel:  rdData_nxt = {24'h000000, sel_r};
            ParLongTerm:  rdData_nxt = widen(peak_r[0]);
            ParShortTerm: rdData_nxt = widen(peak_r[1]);
            ParPeakVdc:   rdData_nxt = widen(peak_r[2]);
            ParMeanVdc:   rdData_nxt = widen(meanVal[0]);
            ParPeakSink:  rdData_nxt = widen(peak_r[3]);
            ParMeanSink:  rdData_nxt = widen(meanVal[1]);
            ParPeakIns:   rdData_nxt = widen(peak_r[4]);
            ParMeanIns:   rdData_nxt = widen(meanVal[2]);
            ParPeakCur:   rdData_nxt = widen(peak_r[5]);
            ParMeanCur:   rdData_nxt = widen(meanVal[3]);
            ParPeakPpos:  rdData_nxt = widen(peak_r[6]);
            ParPeakPneg:  rdData_nxt = widen(peak_r[7]);
            ParMeanPow:   rdData_nxt = widen(meanVal[4]);
            ParEnergyPos: rdData_nxt = energyPos_r;
            ParEnergyNeg: rdData_nxt = energyNeg_r;
            default:      rdData_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_r  <= '0;
         rdValid_r <= 1'b0;
      end else if (ce) begin
         rdData_r  <= rdData_nxt;
         rdValid_r <= rdValid_nxt;
      end
   end

   assign rdData  = rdData_r;
   assign rdValid = rdValid_r;

   // ==========================================================
   // Checks
   sequence selWrite(sel_t code);
      ce && selWrEn && selWrData == code ##1 ce;
   endsequence

   chk_sel_once: assert property ( // [R21]
      @(posedge clk) disable iff (!reset_n)
      ce && clearPend_r && !selWrEn |=> clearMask == '0)
      else $error("selector cleared twice for one write");

   chk_sel_none: assert property ( // [R13]
      @(posedge clk) disable iff (!reset_n)
      ce && selWrEn && selWrData == SelNone |=> clearMask == '0)
      else $error("selector 0 produced a clear");

   chk_single_entry: assert property ( // [R14] [R12]
      @(posedge clk) disable iff (!reset_n)
      selWrite(8'h03) |=> peak_r[2] == '0 && peak_r[0] == $past(peak_r[0]))
      else $error("selector 3 did not clear only Vdc peak");

   chk_all_peaks: assert property ( // [R16]
      @(posedge clk) disable iff (!reset_n)
      selWrite(SelAllPeaks) |=> peaksZero
         && energyPos_r >= $past(energyPos_r))
      else $error("selector 100 left a peak set");

   chk_all_values: assert property ( // [R18]
      @(posedge clk) disable iff (!reset_n)
      selWrite(SelAllValues) |=> peaksZero && energyPos_r == '0
         && energyNeg_r == '0 ##1 ce [*2] ##0 meanVal[0] == '0)
      else $error("selector 102 left memory set");

   chk_energy_clear: assert property ( // [R15]
      @(posedge clk) disable iff (!reset_n)
      selWrite(SelEnergyNeg) |=> energyNeg_r == '0)
      else $error("selector 17 left generating energy");

   chk_peak_hold: assert property ( // [R6] [R11]
      @(posedge clk) disable iff (!reset_n)
      ce && sampleValid && clearMask == '0
      |=> peak_r[2] >= $past(dcLinkVoltage) && peak_r[5] >= $past(peak_r[5]))
      else $error("peak value dropped without clear");

   // Motoring sample must add, unless already saturated
   chk_energy_grow: assert property ( // [R10] [R9]
      @(posedge clk) disable iff (!reset_n)
      ce && sampleValid && activePower > 0 && clearMask == '0
      |=> (energyPos_r > $past(energyPos_r) || energyPos_r == EnergyMax)
         && energyNeg_r == $past(energyNeg_r))
      else $error("motoring energy did not grow");

   chk_read_status: assert property ( // [R19]
      @(posedge clk) disable iff (!reset_n)
      ce && rdEn && rdIndex == ParStatus
      |=> rdValid && rdData == {24'h000000, $past(statusWord)})
      else $error("status read wrong");

endmodule

// ### bench/value_reader.sv
// Reader model of the party fetching memory entries
module value_reader (
   // Clock
   input  wire logic               clk,
   // Read port
   output logic                    rdEn,
   output drive_value_pkg::index_t rdIndex,
   input  wire logic               rdValid,
   input  drive_value_pkg::data_t  rdData
);
   timeunit 1ns;
   timeprecision 1ps;
   import drive_value_pkg::*;
   initial rdEn = 1'b0;
   initial rdIndex = '0;
   // Pulse a request, take the answer at its edge
   task automatic read(input index_t i, output data_t d, output int n);
      n = 0;
      @(posedge clk);
      #1 rdEn = 1'b1;
      rdIndex = i;
      @(posedge clk);
      #1 rdEn = 1'b0;
      rdIndex = ~i;
      do begin
         @(posedge clk);
         n++;
      end while (rdValid !== 1'b1 && n < 8);
      d = rdData;
      #1;
   endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench of the drive value memory
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import drive_value_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        ce = 1'b1;
   logic        pinA = 1'b0;
   logic        pinB = 1'b0;
   logic        smpl = 1'b0;
   logic        selWr = 1'b0;
   logic [7:0]  flags = 8'h00;
   wire  [3:0]  src;
   value_t      v = '0;
   value_t      p = '0;
   sel_t        selData = '0;
   logic        rdEn, rdValid;
   logic [14:0] m = '0;
   index_t      rdIndex;
   data_t       rdData, d;
   int          err_total = 0;
   int          check_count = 0;
   int          lat;

   always #25 clk = ~clk;

   drive_value_memory drive_value_memory_inst (.clk(clk),
      .reset_n(reset_n), .ce(ce), .safetyPinA(pinA), .safetyPinB(pinB),
      .inputMissingA(flags[0]), .inputMissingB(flags[1]),
      .switchOffA(flags[2]), .switchOffB(flags[3]), .timeoutA(flags[4]),
      .timeoutB(flags[5]), .diagnosisError(flags[6]),
      .faultErrorFlag(flags[7]), .safetyInputA(src[3]),
      .safetyInputAInv(src[2]), .safetyInputB(src[1]),
      .safetyInputBInv(src[0]), .sampleValid(smpl), .longTermUtil(v),
      .shortTermUtil(v), .dcLinkVoltage(v), .heatSinkTemperature(v),
      .insideTemperature(v), .currentMagnitude(v), .activePower(p),
      .selWrEn(selWr), .selWrData(selData), .rdEn(rdEn),
      .rdIndex(rdIndex), .rdData(rdData), .rdValid(rdValid));
   value_reader value_reader_inst (.clk(clk), .rdEn(rdEn),
      .rdIndex(rdIndex), .rdValid(rdValid), .rdData(rdData));

   function automatic index_t idxOf(int k);
      return index_t'(k < 2 ? 231 + k : k < 13 ? 285 + k : 288 + k);
   endfunction
   // Entries after the two standard samples
   function automatic data_t expOf(int k);
      case (k)
         3, 5, 7, 9: return 32'h14;
         10, 13: return 32'h64;
         11, 14: return 32'h28;
         default: return 32'h1e;
      endcase
   endfunction
   task automatic cmp(input data_t g, input data_t e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk(input index_t i, input data_t e);
      value_reader_inst.read(i, d, lat);
      cmp(d, e);
      cmp(32'(lat), 32'h1);
   endtask
   task automatic chkAll(input logic [14:0] c);
      for (int k = 0; k < 15; k++)
         chk(idxOf(k), c[k] ? '0 : expOf(k));
   endtask
   task automatic samp(input value_t a, input value_t b);
      @(posedge clk);
      #1 smpl = 1'b1;
      v = a;
      p = b;
      @(posedge clk);
      #1 smpl = 1'b0;
   endtask
   task automatic load();
      samp(16'sh000a, 16'sh0064);
      samp(16'sh001e, -16'sh0028);
      repeat (3) @(posedge clk);
   endtask
   task automatic sel(input sel_t s);
      @(posedge clk);
      #1 selWr = 1'b1;
      selData = s;
      @(posedge clk);
      #1 selWr = 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      #1 reset_n = 1'b1;
      cmp(32'(src), 32'h5);
      for (int b = 0; b < 8; b++) begin
         flags = 8'h01 << b;
         chk(ParStatus, 32'h1 << b);
      end
      flags = 8'h03;
      chk(ParStatus, 32'h3);
      flags = 8'h00;
      chk(ParStatus, 32'h0);
      pinA = 1'b1;
      repeat (4) @(posedge clk);
      #1 cmp(32'(src), 32'h9);
      pinA = 1'b0;
      pinB = 1'b1;
      repeat (4) @(posedge clk);
      #1 cmp(32'(src), 32'h6);
      load();
      sel(8'h00);
      chkAll(m);
      for (int k = 1; k < 18; k++) begin
         sel(sel_t'(k));
         if (k < 14 || k > 15)
            m[k < 14 ? k - 1 : k - 3] = 1'b1;
         chkAll(m);
      end
      load();
      sel(8'h64);
      chkAll(15'h0d57);
      sel(8'h65);
      chkAll(15'h1fff);
      sel(8'h66);
      chkAll(15'h7fff);
      // Sample while frozen must not land
      ce = 1'b0;
      samp(16'sh0040, 16'sh0000);
      ce = 1'b1;
      samp(16'sh0032, 16'sh0000);
      repeat (3) @(posedge clk);
      chk(ParPeakVdc, 32'h32);
      sel(8'h66);
      chk(ParPeakVdc, 32'h0);
      chk(ParResetSel, 32'h66);
      chk(10'h3ff, 32'h0);
      report_and_stop();
   end

   initial begin
      #1000000;
      err_total++;
      report_and_stop();
   end
endmodule
